/* File: verif/tb.sv */
// Self-checking bench of the wake and report block.
// Assumes the PHY model on the management port and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [31:0] PHY_EXP = 32'hA503_A502;
   logic        clk = 1'b0;
   logic        rst_n, psel, pen, pwr, pready, pslverr, susp, hres, feat, allow, magic;
   logic        pri, sec, pin_n, phyint, lchk, lbad, suspd, rwake, irq, mdc, mdo, mdoe, drv, pbit;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [63:0] rep;
   wire logic   mdio;
   int          n_errors = 0;
   int          comparisons = 0;
   int          cycles = 0;
   assign mdio = mdoe ? mdo : (drv ? pbit : 1'b1);
   uwk_wake_report #(.POLL_CYC(700)) dut (
      .CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .SUSPEND_I(susp), .HOST_RESUME_I(hres), .REMOTE_WAKE_FEATURE_I(feat), .EEPROM_WAKE_ALLOW_I(allow),
      .EEPROM_PHY_REG_SEL_I(16'h0302), .MAGIC_PACKET_I(magic), .PRIMARY_LINK_UP_I(pri),
      .SECONDARY_LINK_UP_I(sec), .EXTERNAL_WAKE_PIN_N_I(pin_n), .PHY_INTERRUPT_LEVEL_I(phyint),
      .LEN_CHECK_I(lchk), .LEN_PARITY_BAD_I(lbad), .SUSPENDED_O(suspd), .REMOTE_WAKE_O(rwake),
      .REPORT_O(rep), .IRQ_O(irq), .MDC_O(mdc), .MDIO_O(mdo), .MDIO_OE_O(mdoe), .MDIO_I(mdio));
   uwk_phy_model phy (.mdc_i(mdc), .mdio_oe_i(mdoe), .mdio_i(mdio), .drv_o(drv), .bit_o(pbit));
   always #50 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic settle();
      @(negedge clk);
   endtask
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      cyc(1);
      pen <= 1'b1;
      do begin
         cyc(1);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
      cyc(1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic ee);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk("read data", d, q);
      chk("slave error", ee, e);
   endtask
   task automatic finish_test();
      if (n_errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd(uwk_pkg::ADDR_CTRL, 32'h0000_0000, 1'b0);
      wr(uwk_pkg::ADDR_CTRL, 32'h0000_0006);
      rd(uwk_pkg::ADDR_CTRL, 32'h0000_0000, 1'b0);
      rd(uwk_pkg::ADDR_PHYADR, 32'h0000_0001, 1'b0);
      rd(8'h18, 32'h0000_0000, 1'b1);
   endtask
   task automatic t_report();
      pri    <= 1'b1;
      phyint <= 1'b1;
      cyc(2);
      settle();
      chk("status", 8'h09, rep[47:40]);
      cyc(1);
      rd(uwk_pkg::ADDR_STATE, 32'h0000_0009, 1'b0);
      pri    <= 1'b0;
      sec    <= 1'b1;
      phyint <= 1'b0;
      lchk   <= 1'b1;
      lbad   <= 1'b1;
      cyc(1);
      lchk <= 1'b0;
      cyc(2);
      settle();
      chk("report head", 32'hA100_0600, rep[63:32]);
      cyc(1);
      sec  <= 1'b0;
      lchk <= 1'b1;
      lbad <= 1'b0;
      cyc(1);
      lchk <= 1'b0;
      cyc(2);
      settle();
      chk("status", 8'h00, rep[47:40]);
      cyc(1);
   endtask
   task automatic try_wake(input int ev, input logic rw, input logic up);
      susp <= 1'b1;
      cyc(1);
      susp <= 1'b0;
      case (ev)
         0: magic <= 1'b1;
         1: pri <= 1'b1;
         2: sec <= 1'b1;
         3: pin_n <= 1'b0;
         default: hres <= 1'b1;
      endcase
      cyc(1);
      magic <= 1'b0;
      pin_n <= 1'b1;
      hres  <= 1'b0;
      settle();
      chk("remote wake", rw, rwake);
      chk("suspended", !up, suspd);
      cyc(1);
      hres <= 1'b1;
      pri  <= 1'b0;
      sec  <= 1'b0;
      cyc(1);
      hres <= 1'b0;
      cyc(1);
   endtask
   task automatic t_wake();
      try_wake(4, 1'b0, 1'b1);
      try_wake(0, 1'b0, 1'b0);
      allow <= 1'b1;
      try_wake(3, 1'b0, 1'b0);
      feat <= 1'b1;
      wr(uwk_pkg::ADDR_CTRL, 32'h0000_0000);
      try_wake(0, 1'b0, 1'b0);
      try_wake(1, 1'b0, 1'b0);
      try_wake(3, 1'b1, 1'b1);
      wr(uwk_pkg::ADDR_CTRL, 32'h0000_0004);
      try_wake(0, 1'b1, 1'b1);
      wr(uwk_pkg::ADDR_CTRL, 32'h0000_0002);
      try_wake(2, 1'b1, 1'b1);
      try_wake(1, 1'b1, 1'b1);
      try_wake(4, 1'b0, 1'b1);
   endtask
   task automatic t_irq();
      rd(uwk_pkg::ADDR_IRQST, 32'h0000_001F, 1'b0);
      wr(uwk_pkg::ADDR_IRQMSK, 32'h0000_0001);
      settle();
      chk("irq", 1'b1, irq);
      cyc(1);
      wr(uwk_pkg::ADDR_IRQMSK, 32'h0000_0000);
      settle();
      chk("irq", 1'b0, irq);
      cyc(1);
      wr(uwk_pkg::ADDR_IRQMSK, 32'h0000_0001);
      wr(uwk_pkg::ADDR_IRQST, 32'h0000_0001);
      settle();
      chk("irq", 1'b0, irq);
      cyc(1);
   endtask
   task automatic t_phy();
      logic [31:0] q;
      logic        e;
      for (int k = 0; k < 40; k++) begin
         apb(1'b0, uwk_pkg::ADDR_PHYVAL, 32'h0000_0000, q, e);
         if (q === PHY_EXP)
            break;
         cyc(100);
      end
      chk("phy values", PHY_EXP, q);
      settle();
      chk("report", {32'hA100_0000, PHY_EXP}, rep);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         finish_test();
      end
   end
   initial begin
      {rst_n, psel, pen, pwr, susp, hres, feat, allow, magic, pri, sec, phyint, lchk, lbad} = '0;
      pin_n  = 1'b1;
      paddr  = 8'h00;
      pwdata = 32'h0000_0000;
      cyc(12);
      rst_n <= 1'b1;
      cyc(1);
      t_regs();
      t_report();
      t_wake();
      t_irq();
      t_phy();
      finish_test();
   end
endmodule // tb
`default_nettype wire

/* File: verif/uwk_phy_model.sv */
// Management-port model of the primary PHY; answers every read.
// Assumes a pull-up on the data line and MDC idle between frames.
`timescale 1ns/1ps
`default_nettype none
module uwk_phy_model (
   input  wire logic mdc_i,
   input  wire logic mdio_oe_i,
   input  wire logic mdio_i,
   output logic      drv_o,
   output logic      bit_o
);
   int          n = 0;
   logic [15:0] sr = '0;
   logic [15:0] val = '0;
   // Counts rising MDC edges of a frame and captures the register number.
   always @(posedge mdc_i) begin
      sr <= {sr[14:0], mdio_i};
      n  <= (n == 63 || (n == 0 && !mdio_oe_i)) ? 0 : n + 1;
      if (n == 46)
         val <= {8'hA5, 3'b000, sr[4:0]};
   end
   // Drives turnaround zero then data MSB first after falling MDC.
   always @(negedge mdc_i) begin
      drv_o <= (n >= 47 && n <= 63);
      bit_o <= (n == 47) ? 1'b0 : val[63 - n];
   end
endmodule // uwk_phy_model
`default_nettype wire

/* File: verif/uwk_wake_report_props.sv */
// Assertions on the wake and report ports of the block.
// Assumes it is bound to the top module; control writes are tracked here.
`timescale 1ns/1ps
`default_nettype none
module uwk_wake_report_props (
   input wire logic        CORE_CLK_I,
   input wire logic        RST_N_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [7:0]  PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic        HOST_RESUME_I,
   input wire logic        REMOTE_WAKE_FEATURE_I,
   input wire logic        EEPROM_WAKE_ALLOW_I,
   input wire logic        MAGIC_PACKET_I,
   input wire logic        PRIMARY_LINK_UP_I,
   input wire logic        SECONDARY_LINK_UP_I,
   input wire logic        EXTERNAL_WAKE_PIN_N_I,
   input wire logic        PHY_INTERRUPT_LEVEL_I,
   input wire logic        LEN_CHECK_I,
   input wire logic        LEN_PARITY_BAD_I,
   input wire logic        SUSPENDED_O,
   input wire logic        REMOTE_WAKE_O,
   input wire logic [63:0] REPORT_O
);
   logic wake_ok;
   logic ok_r;
   logic link_en_r;
   logic magic_en_r;
   assign wake_ok = EEPROM_WAKE_ALLOW_I && REMOTE_WAKE_FEATURE_I;
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         ok_r       <= 1'b0;
         link_en_r  <= 1'b0;
         magic_en_r <= 1'b0;
      end else begin
         ok_r <= wake_ok;
         if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == uwk_pkg::ADDR_CTRL) begin
            link_en_r  <= PWDATA_I[uwk_pkg::CTRL_LINK_BIT];
            magic_en_r <= PWDATA_I[uwk_pkg::CTRL_MAGIC_BIT];
         end
      end
   end
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);
   sequence armed_s;
      SUSPENDED_O && !HOST_RESUME_I && wake_ok;
   endsequence
   sequence bad_chk_s;
      LEN_CHECK_I && LEN_PARITY_BAD_I ##1 !LEN_CHECK_I;
   endsequence
   sequence good_chk_s;
      LEN_CHECK_I && !LEN_PARITY_BAD_I ##1 !LEN_CHECK_I;
   endsequence
   sequence link_up_s;
      $rose(PRIMARY_LINK_UP_I) || $rose(SECONDARY_LINK_UP_I);
   endsequence
   host_wake_a: assert property (SUSPENDED_O && HOST_RESUME_I |=> !SUSPENDED_O && !REMOTE_WAKE_O)
      else $error("host resume did not end suspend");
   no_self_wake_a: assert property (REMOTE_WAKE_O |-> ok_r)
      else $error("self wake without both allow flags");
   magic_wake_a: assert property (armed_s ##0 (MAGIC_PACKET_I && magic_en_r)
      |=> REMOTE_WAKE_O && !SUSPENDED_O)
      else $error("enabled magic packet did not wake");
   link_wake_a: assert property (armed_s ##0 link_en_r ##0 link_up_s |=> REMOTE_WAKE_O && !SUSPENDED_O)
      else $error("enabled link-up did not wake");
   pin_wake_a: assert property (armed_s ##0 $fell(EXTERNAL_WAKE_PIN_N_I) |=> REMOTE_WAKE_O)
      else $error("wake pin pulse did not wake");
   report_frame_a: assert property ($past(RST_N_I) |-> REPORT_O[63:32] ==? 32'hA100_??00
      && REPORT_O[47:44] == 4'h0)
      else $error("report fixed bytes wrong");
   status_bits_a: assert property ($past(RST_N_I) |-> REPORT_O[40] == $past(PRIMARY_LINK_UP_I)
      && REPORT_O[41] == $past(SECONDARY_LINK_UP_I) && REPORT_O[43] == $past(PHY_INTERRUPT_LEVEL_I))
      else $error("status bits do not follow inputs");
   len_bad_a: assert property (bad_chk_s |=> REPORT_O[42])
      else $error("length error not reported");
   len_good_a: assert property (good_chk_s |=> !REPORT_O[42])
      else $error("length error not cleared");
endmodule // uwk_wake_report_props
bind uwk_wake_report uwk_wake_report_props u_props (.*);
`default_nettype wire

/* File: verilog/uwk_mdio_rd.sv */
// Management serial read engine: reads one 16-bit PHY register per start.
// Assumes the PHY answers during the turnaround like a clause 22 device.
`timescale 1ns/1ps
`default_nettype none
module uwk_mdio_rd (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        start_i,
   input  wire logic [4:0]  phy_i,
   input  wire logic [4:0]  reg_i,
   output logic             busy_o,
   output logic             done_o,
   output logic [15:0]      data_o,
   output logic             mdc_o,
   output logic             mdio_o,
   output logic             mdio_oe_o,
   input  wire logic        mdio_i
);
   localparam int HW = uwk_pkg::MDC_HALF_CYC;
   logic [3:0]  half_r;
   logic [6:0]  bit_r;
   logic [13:0] cmd_r;
   logic        tick;

   assign tick = busy_o && (half_r == 4'(HW - 1));

   ////////////////////////////////////////////////////////////////////
   // Half-period timer and clock.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !busy_o || tick) begin
         half_r <= 4'h0;
      end else begin
         half_r <= half_r + 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         busy_o <= 1'b0;
         mdc_o  <= 1'b0;
         bit_r  <= 7'h00;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (!busy_o && start_i) begin
            busy_o <= 1'b1;
            bit_r  <= 7'h00;
         end else if (tick) begin
            mdc_o <= !mdc_o;
            if (mdc_o) begin
               bit_r <= bit_r + 7'h01;
               if (bit_r == 7'(uwk_pkg::MD_ALL_BITS - 1)) begin
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Output shifting on the falling edge, sampling on the rising edge.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cmd_r     <= 14'h0000;
         mdio_o    <= 1'b1;
         mdio_oe_o <= 1'b0;
         data_o    <= 16'h0000;
      end else if (!busy_o && start_i) begin
         cmd_r     <= {4'b0110, phy_i, reg_i};
         mdio_o    <= 1'b1;
         mdio_oe_o <= 1'b1;
      end else if (tick && mdc_o) begin
         if (bit_r < 7'(uwk_pkg::MD_PRE_BITS - 1)) begin
            mdio_o <= 1'b1;
         end else if (bit_r < 7'(uwk_pkg::MD_PRE_BITS + uwk_pkg::MD_CMD_BITS - 1)) begin
            mdio_o <= cmd_r[13];
            cmd_r  <= {cmd_r[12:0], 1'b0};
         end else begin
            mdio_oe_o <= 1'b0;
         end
      end else if (tick && !mdc_o && bit_r >= 7'(uwk_pkg::MD_ALL_BITS - 16)) begin
         data_o <= {data_o[14:0], mdio_i};
      end
   end
endmodule // uwk_mdio_rd
`default_nettype wire

/* File: verilog/uwk_pkg.sv */
// Constants of the suspend-wakeup and status-report block.
// Assumes a 10 MHz core clock and a 32-bit APB register bus.
package uwk_pkg;
   // Register byte offsets.
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATE  = 8'h04;
   localparam logic [7:0] ADDR_PHYVAL = 8'h08;
   localparam logic [7:0] ADDR_IRQST  = 8'h0C;
   localparam logic [7:0] ADDR_IRQMSK = 8'h10;
   localparam logic [7:0] ADDR_PHYADR = 8'h14;
   // Control register fields, write only.
   localparam int CTRL_LINK_BIT  = 1;
   localparam int CTRL_MAGIC_BIT = 2;
   // State register fields above the status byte.
   localparam int STATE_SUSP_BIT = 8;
   // Interrupt status fields.
   localparam int IRQ_W          = 6;
   localparam int IRQ_LOCAL_WAKE = 0;
   localparam int IRQ_HOST_WAKE  = 1;
   localparam int IRQ_LEN_ERR    = 2;
   localparam int IRQ_LINK_CHG   = 3;
   localparam int IRQ_PHYINT_CHG = 4;
   localparam int IRQ_REFRESH    = 5;
   // Report layout.
   localparam logic [7:0] REPORT_HEAD = 8'hA1;
   localparam logic [7:0] REPORT_ZERO = 8'h00;
   localparam logic [4:0] PHY_ADDR_RST = 5'h01;
   // Timing.
   localparam int CLK_NS      = 100;
   localparam int MDC_HALF_NS = 333;
   localparam int MDC_HALF_CYC = (MDC_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int POLL_US     = 1000;
   localparam int POLL_CYC    = (POLL_US * 1000) / CLK_NS;
   // Management frame lengths.
   localparam int MD_PRE_BITS = 32;
   localparam int MD_CMD_BITS = 14;
   localparam int MD_ALL_BITS = 64;
   // Suspend states.
   typedef enum logic [0:0] {
      ST_RUN  = 1'b0,
      ST_SUSP = 1'b1
   } uwk_state_t;
endpackage

/* File: verilog/uwk_wake_report.sv */
// Suspend-wakeup decision and interrupt-endpoint status report with APB.
// Assumes the USB core flags suspend, host resume and remote-wake feature.
//
// How it works
// - Host resume ends suspend whatever the wake settings are; prior mode kept.
// - No local wake unless EEPROM wake-allow and host remote-wake feature set.
// - Local wake: magic if enabled, link-up if enabled, or a falling edge on the wake pin.
// - Report is A1, 00, status, 00, then two 16-bit PHY values.
// - Status byte: link, link, length error, PHY interrupt, four zero bits.
// - Status bit 0 is one while primary link is up.
// - Status bit 1 is one while secondary link is up.
// - Bit 2 is one after a length parity error, zero after good parity.
// - Bit 3 shows the PHY interrupt input level.
// - Bytes 5 and 6 hold the PHY register named by EEPROM high byte.
// - Bytes 7 and 8 hold the PHY register named by EEPROM low byte.
// - Wake-on-link enable is a write-only bit, zero after reset.
// - Wake-on-magic enable is a write-only bit, zero after reset.
`timescale 1ns/1ps
`default_nettype none
module uwk_wake_report #(
   parameter int POLL_CYC = uwk_pkg::POLL_CYC
) (
   input  wire logic        CORE_CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic [31:0]      PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic        SUSPEND_I,
   input  wire logic        HOST_RESUME_I,
   input  wire logic        REMOTE_WAKE_FEATURE_I,
   input  wire logic        EEPROM_WAKE_ALLOW_I,
   input  wire logic [15:0] EEPROM_PHY_REG_SEL_I,
   input  wire logic        MAGIC_PACKET_I,
   input  wire logic        PRIMARY_LINK_UP_I,
   input  wire logic        SECONDARY_LINK_UP_I,
   input  wire logic        EXTERNAL_WAKE_PIN_N_I,
   input  wire logic        PHY_INTERRUPT_LEVEL_I,
   input  wire logic        LEN_CHECK_I,
   input  wire logic        LEN_PARITY_BAD_I,
   output logic             SUSPENDED_O,
   output logic             REMOTE_WAKE_O,
   output logic [63:0]      REPORT_O,
   output logic             IRQ_O,
   output logic             MDC_O,
   output logic             MDIO_O,
   output logic             MDIO_OE_O,
   input  wire logic        MDIO_I
);
   uwk_pkg::uwk_state_t state_r;
   logic                wake_on_link_enable_r;
   logic                wake_on_magic_enable_r;
   logic                bulk_out_length_error_r;
   logic                primary_link_up_r;
   logic                secondary_link_up_r;
   logic                pin_n_r;
   logic                phy_int_r;
   logic                hist_ok_r;
   logic [4:0]          phy_addr_r;
   logic [15:0]         phy_val_a_r;
   logic [15:0]         phy_val_b_r;
   logic [7:0]          status_byte;
   logic [uwk_pkg::IRQ_W-1:0] irq_st_r;
   logic [uwk_pkg::IRQ_W-1:0] irq_msk_r;
   logic [uwk_pkg::IRQ_W-1:0] irq_ev;
   logic [31:0]         poll_r;
   logic                poll_sel_r;
   logic                md_start;
   logic                md_busy;
   logic                md_done;
   logic [15:0]         md_data;
   logic                self_wake_ok;
   logic                local_event;
   logic                link_rise;
   logic                wr_acc;
   logic                setup;
   logic                mapped;
   logic [31:0]         rd_nxt;

   ////////////////////////////////////////////////////////////////////
   // APB decode: data is latched in the setup cycle, zero wait access.
   assign setup  = PSEL_I && !PENABLE_I;
   assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
   assign PREADY_O = 1'b1;

   always_comb begin
      mapped = 1'b1;
      rd_nxt = 32'h0000_0000;
      unique case (PADDR_I)
         uwk_pkg::ADDR_CTRL: begin
            rd_nxt = 32'h0000_0000;
         end
         uwk_pkg::ADDR_STATE: begin
            rd_nxt = {23'h00_0000, SUSPENDED_O, status_byte};
         end
         uwk_pkg::ADDR_PHYVAL: begin
            rd_nxt = {phy_val_a_r, phy_val_b_r};
         end
         uwk_pkg::ADDR_IRQST: begin
            rd_nxt = {26'h000_0000, irq_st_r};
         end
         uwk_pkg::ADDR_IRQMSK: begin
            rd_nxt = {26'h000_0000, irq_msk_r};
         end
         uwk_pkg::ADDR_PHYADR: begin
            rd_nxt = {27'h000_0000, phy_addr_r};
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         PRDATA_O <= 32'h0000_0000;
      end else if (setup) begin
         PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Slave error stands from the setup edge until the select falls.
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         PSLVERR_O <= 1'b0;
      end else if (setup) begin
         PSLVERR_O <= !mapped;
      end else if (!PSEL_I) begin
         PSLVERR_O <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Writable registers.
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         wake_on_link_enable_r  <= 1'b0;
         wake_on_magic_enable_r <= 1'b0;
      end else if (wr_acc && PADDR_I == uwk_pkg::ADDR_CTRL) begin
         wake_on_link_enable_r  <= PWDATA_I[uwk_pkg::CTRL_LINK_BIT];
         wake_on_magic_enable_r <= PWDATA_I[uwk_pkg::CTRL_MAGIC_BIT];
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         irq_msk_r <= '0;
      end else if (wr_acc && PADDR_I == uwk_pkg::ADDR_IRQMSK) begin
         irq_msk_r <= PWDATA_I[uwk_pkg::IRQ_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Address of the PHY that the management reads go to.
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         phy_addr_r <= uwk_pkg::PHY_ADDR_RST;
      end else if (wr_acc && PADDR_I == uwk_pkg::ADDR_PHYADR) begin
         phy_addr_r <= PWDATA_I[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Input history for edge detection.
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         primary_link_up_r   <= 1'b0;
         secondary_link_up_r <= 1'b0;
      end else begin
         primary_link_up_r   <= PRIMARY_LINK_UP_I;
         secondary_link_up_r <= SECONDARY_LINK_UP_I;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         pin_n_r   <= 1'b1;
         phy_int_r <= 1'b0;
      end else begin
         pin_n_r   <= EXTERNAL_WAKE_PIN_N_I;
         phy_int_r <= PHY_INTERRUPT_LEVEL_I;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Edges count only from the second edge after reset, so an input already active at release is no event.
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         hist_ok_r <= 1'b0;
      end else begin
         hist_ok_r <= 1'b1;
      end
   end

   assign link_rise = hist_ok_r && ((PRIMARY_LINK_UP_I && !primary_link_up_r) ||
                                    (SECONDARY_LINK_UP_I && !secondary_link_up_r));

   ////////////////////////////////////////////////////////////////////
   // Wake decision.
   assign self_wake_ok = EEPROM_WAKE_ALLOW_I && REMOTE_WAKE_FEATURE_I;
   assign local_event = (MAGIC_PACKET_I && wake_on_magic_enable_r) ||
                        (link_rise && wake_on_link_enable_r) ||
                        (!EXTERNAL_WAKE_PIN_N_I && pin_n_r && hist_ok_r);

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         state_r       <= uwk_pkg::ST_RUN;
         REMOTE_WAKE_O <= 1'b0;
      end else begin
         REMOTE_WAKE_O <= 1'b0;
         unique case (state_r)
            uwk_pkg::ST_RUN: begin
               if (SUSPEND_I && !HOST_RESUME_I) begin
                  state_r <= uwk_pkg::ST_SUSP;
               end
            end
            uwk_pkg::ST_SUSP: begin
               if (HOST_RESUME_I) begin
                  state_r <= uwk_pkg::ST_RUN;
               end else if (self_wake_ok && local_event) begin
                  state_r       <= uwk_pkg::ST_RUN;
                  REMOTE_WAKE_O <= 1'b1;
               end
            end
         endcase
      end
   end

   // Settings are never touched by suspend, so resume restores them.
   assign SUSPENDED_O = (state_r == uwk_pkg::ST_SUSP);

   ////////////////////////////////////////////////////////////////////
   // Length error flag follows the latest bulk-out length check.
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         bulk_out_length_error_r <= 1'b0;
      end else if (LEN_CHECK_I) begin
         bulk_out_length_error_r <= LEN_PARITY_BAD_I;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status byte and report.
   assign status_byte = {4'h0,
                         PHY_INTERRUPT_LEVEL_I,
                         bulk_out_length_error_r,
                         SECONDARY_LINK_UP_I,
                         PRIMARY_LINK_UP_I};

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         REPORT_O <= 64'h0000_0000_0000_0000;
      end else begin
         REPORT_O <= {uwk_pkg::REPORT_HEAD, uwk_pkg::REPORT_ZERO,
                      status_byte, uwk_pkg::REPORT_ZERO,
                      phy_val_a_r, phy_val_b_r};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Periodic PHY polling, alternating between the two selected registers.
   assign md_start = (poll_r == 32'h0000_0000) && !md_busy;

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         poll_r <= 32'h0000_0000;
      end else if (md_start) begin
         poll_r <= 32'(POLL_CYC - 1);
      end else if (poll_r != 32'h0000_0000) begin
         poll_r <= poll_r - 32'h0000_0001;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         poll_sel_r <= 1'b0;
      end else if (md_done) begin
         poll_sel_r <= !poll_sel_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Each reply lands in the report half that its register belongs to.
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         phy_val_a_r <= 16'h0000;
      end else if (md_done && !poll_sel_r) begin
         phy_val_a_r <= md_data;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         phy_val_b_r <= 16'h0000;
      end else if (md_done && poll_sel_r) begin
         phy_val_b_r <= md_data;
      end
   end

   uwk_mdio_rd u_mdio (
      .clk_i     (CORE_CLK_I),
      .rst_n_i   (RST_N_I),
      .start_i   (md_start),
      .phy_i     (phy_addr_r),
      .reg_i     (poll_sel_r ? EEPROM_PHY_REG_SEL_I[4:0] : EEPROM_PHY_REG_SEL_I[12:8]),
      .busy_o    (md_busy),
      .done_o    (md_done),
      .data_o    (md_data),
      .mdc_o     (MDC_O),
      .mdio_o    (MDIO_O),
      .mdio_oe_o (MDIO_OE_O),
      .mdio_i    (MDIO_I)
   );

   ////////////////////////////////////////////////////////////////////
   // Interrupt status: sticky, write one to clear, set wins over clear.
   always_comb begin
      irq_ev = '0;
      irq_ev[uwk_pkg::IRQ_LOCAL_WAKE] = REMOTE_WAKE_O;
      irq_ev[uwk_pkg::IRQ_HOST_WAKE]  = SUSPENDED_O && HOST_RESUME_I;
      irq_ev[uwk_pkg::IRQ_LEN_ERR]    = LEN_CHECK_I && LEN_PARITY_BAD_I;
      irq_ev[uwk_pkg::IRQ_LINK_CHG]   = hist_ok_r && ((PRIMARY_LINK_UP_I != primary_link_up_r) ||
                                                      (SECONDARY_LINK_UP_I != secondary_link_up_r));
      irq_ev[uwk_pkg::IRQ_PHYINT_CHG] = hist_ok_r && (PHY_INTERRUPT_LEVEL_I != phy_int_r);
      irq_ev[uwk_pkg::IRQ_REFRESH]    = md_done;
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         irq_st_r <= '0;
      end else if (wr_acc && PADDR_I == uwk_pkg::ADDR_IRQST) begin
         irq_st_r <= (irq_st_r & ~PWDATA_I[uwk_pkg::IRQ_W-1:0]) | irq_ev;
      end else begin
         irq_st_r <= irq_st_r | irq_ev;
      end
   end

   assign IRQ_O = |(irq_st_r & irq_msk_r);
endmodule // uwk_wake_report
`default_nettype wire
